// ==== inc/gpiod_pkg.sv ====
// package for the general-purpose port direction and data block
package gpiod_pkg;

  localparam int unsigned GPIOD_NPORT = 12;
  localparam int unsigned GPIOD_NBIT  = 4;
  localparam int unsigned GPIOD_NBITP = 8;  // bit-selectable ports come first
  localparam int unsigned GPIOD_NGRP  = 4;  // group ports follow them

  typedef logic [GPIOD_NBIT-1:0]                  gpiod_nib_t;
  typedef logic [GPIOD_NPORT-1:0][GPIOD_NBIT-1:0] gpiod_port_t;

  // pin drive bundle, output enable active low
  typedef struct packed {
    gpiod_port_t out;
    gpiod_port_t oe_n;
  } gpiod_drive_s;

  typedef enum logic [2:0] {
    GPIOD_K_NONE,
    GPIOD_K_DIR,
    GPIOD_K_GROUP,
    GPIOD_K_DATA,
    GPIOD_K_STOP
  } gpiod_kind_e;

  // register indices; byte address is four times the index
  localparam logic [7:0] GPIOD_IDX_DIR_0A  = 8'h6f;  // dir of bit port k at 6f minus k
  localparam logic [7:0] GPIOD_IDX_DIR_0B  = 8'h6e;
  localparam logic [7:0] GPIOD_IDX_DIR_0C  = 8'h6d;
  localparam logic [7:0] GPIOD_IDX_DIR_LO  = 8'h68;
  localparam logic [7:0] GPIOD_IDX_GROUP   = 8'h67;
  localparam logic [7:0] GPIOD_IDX_DATA_LO = 8'h70;
  localparam logic [7:0] GPIOD_IDX_DATA_HI = 8'h7b;
  localparam logic [7:0] GPIOD_IDX_STOP    = 8'h60;

  localparam int unsigned GPIOD_STOP_BIT = 0;

  localparam gpiod_nib_t  GPIOD_DIR_RST   = 4'h0;
  localparam gpiod_nib_t  GPIOD_GROUP_RST = 4'h0;
  localparam gpiod_port_t GPIOD_DATA_RST  = 48'h0000_0000_0000;
  localparam logic        GPIOD_STOP_RST  = 1'b0;

  // pins that exist: port 2a and 2d have no bit 3
  localparam gpiod_port_t GPIOD_PIN_MASK  = 48'hffff_7ff7_ffff;

  localparam logic [1:0] GPIOD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] GPIOD_RESP_SLVERR = 2'h2;

endpackage

// ==== design/gpiod_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpiod_sync #(
  parameter int unsigned WIDTH = 48
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // a zero-width synchroniser cannot be built
  if (WIDTH < 1) begin : g_width_chk
    $error("gpiod_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // gpiod_sync
`default_nettype wire

// ==== design/gpiod_top.sv ====
// general-purpose port direction, data latch and axi4-lite register access
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module gpiod_top
  import gpiod_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire gpiod_port_t         pin_in,
  output var  gpiod_drive_s        pin_drive,
  output var  logic                clock_stop
);

  // refuse widths the decode cannot serve; index bits 9:2 must exist
  if (ADDR_W < 10) begin : g_addr_chk
    $error("gpiod_top: ADDR_W must reach index bits 9:2");
  end
  // the direction concatenation assumes bit ports then four group ports
  if (GPIOD_NBITP + GPIOD_NGRP != GPIOD_NPORT || GPIOD_NGRP != 4) begin : g_port_chk
    $error("gpiod_top: port counts do not match the direction layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // classify a register index
  // unmapped indices fall to none and answer with an error
  function automatic gpiod_kind_e kind_of(input logic [7:0] idx);
    if (idx >= GPIOD_IDX_DIR_LO && idx <= GPIOD_IDX_DIR_0A) return GPIOD_K_DIR;
    else if (idx == GPIOD_IDX_GROUP) return GPIOD_K_GROUP;
    else if (idx >= GPIOD_IDX_DATA_LO && idx <= GPIOD_IDX_DATA_HI) return GPIOD_K_DATA;
    else if (idx == GPIOD_IDX_STOP) return GPIOD_K_STOP;
    else return GPIOD_K_NONE;
  endfunction

  // port number behind a dir or data index
  function automatic logic [3:0] port_of(input logic [7:0] idx, input gpiod_kind_e k);
    logic [7:0] d;
    d = (k == GPIOD_K_DIR) ? (GPIOD_IDX_DIR_0A - idx) : (idx - GPIOD_IDX_DATA_LO);
    return d[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [GPIOD_NBITP-1:0][GPIOD_NBIT-1:0] bit_dir;
  gpiod_nib_t                              group_dir;
  gpiod_port_t                             out_latch;
  logic                                    aw_held;
  logic [7:0]                              aw_idx;
  logic                                    w_held;
  gpiod_nib_t                              w_nib;
  logic                                    w_lane0;
  gpiod_port_t                             pin_sync;

  gpiod_sync #(
    .WIDTH(GPIOD_NPORT * GPIOD_NBIT)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // effective direction and pin view

  gpiod_port_t dir_eff;
  gpiod_port_t in_view;
  gpiod_port_t read_view;

  // group ports replicate one bit over four pins
  // group register bit k steers group port 3a+k
  assign dir_eff = {{4{group_dir[3]}}, {4{group_dir[2]}},
                    {4{group_dir[1]}}, {4{group_dir[0]}}, bit_dir};
  // stopped input buffers read low so floating pins draw nothing
  assign in_view = clock_stop ? GPIOD_DATA_RST : pin_sync;
  // output pins read back their latch, input pins the outside level
  assign read_view = ((dir_eff & out_latch) | (~dir_eff & in_view))
                     & GPIOD_PIN_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // write channel decode

  wire         aw_take   = s_axi_awvalid && s_axi_awready;
  wire         w_take    = s_axi_wvalid && s_axi_wready;
  wire         do_write  = aw_held && w_held && !s_axi_bvalid;
  wire gpiod_kind_e wk   = kind_of(aw_idx);
  wire [3:0]   wport     = port_of(aw_idx, wk);
  wire         wr_en     = do_write && w_lane0;
  wire         next_aw   = do_write ? 1'b0 : (aw_held || aw_take);
  wire         next_w    = do_write ? 1'b0 : (w_held || w_take);

  // readies reopen with the response; a new write then waits for bvalid to drop
  // address and data accepted in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 8'h00;
      w_nib         <= 4'h0;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= GPIOD_RESP_OKAY;
    end else begin
      aw_held       <= next_aw;
      w_held        <= next_w;
      s_axi_awready <= !next_aw;
      s_axi_wready  <= !next_w;
      if (aw_take) aw_idx <= s_axi_awaddr[9:2];
      if (w_take) begin
        w_nib   <= s_axi_wdata[3:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wk == GPIOD_K_NONE) ? GPIOD_RESP_SLVERR : GPIOD_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // stop bit stands in for the clock stop instruction; pins keep their modes
  // register updates; a write with lane 0 off changes nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_dir    <= {GPIOD_NBITP{GPIOD_DIR_RST}};
      group_dir  <= GPIOD_GROUP_RST;
      out_latch  <= GPIOD_DATA_RST;
      clock_stop <= GPIOD_STOP_RST;
    end else if (wr_en) begin
      if (wk == GPIOD_K_DIR) bit_dir[wport[2:0]] <= w_nib;
      if (wk == GPIOD_K_GROUP) group_dir <= w_nib;
      if (wk == GPIOD_K_DATA) out_latch[wport] <= w_nib;
      if (wk == GPIOD_K_STOP) clock_stop <= w_nib[GPIOD_STOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  wire         ar_take   = s_axi_arvalid && s_axi_arready;
  wire [7:0]   ar_idx    = s_axi_araddr[9:2];
  wire gpiod_kind_e rk   = kind_of(ar_idx);
  wire [3:0]   rport     = port_of(ar_idx, rk);
  wire         next_rv   = ar_take || (s_axi_rvalid && !s_axi_rready);
  gpiod_nib_t  rd_nib;

  // read value per register kind
  assign rd_nib = (rk == GPIOD_K_DIR)   ? bit_dir[rport[2:0]] :
                  (rk == GPIOD_K_GROUP) ? group_dir :
                  (rk == GPIOD_K_DATA)  ? read_view[rport] :
                  (rk == GPIOD_K_STOP)  ? {3'h0, clock_stop} : 4'h0;

  // read data is captured at the take, so a later pin change is not seen
  // one read at a time; arready drops while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= GPIOD_RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rv;
      s_axi_rvalid  <= next_rv;
      if (ar_take) begin
        s_axi_rdata <= {28'h0000000, rd_nib};
        s_axi_rresp <= (rk == GPIOD_K_NONE) ? GPIOD_RESP_SLVERR : GPIOD_RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive, registered so pins never glitch on decode
  // absent pins stay undriven whatever their direction bit holds

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_drive.out  <= GPIOD_DATA_RST;
      pin_drive.oe_n <= ~GPIOD_DATA_RST;
    end else begin
      pin_drive.out  <= out_latch & dir_eff & GPIOD_PIN_MASK;
      pin_drive.oe_n <= ~(dir_eff & GPIOD_PIN_MASK);
    end
  end

  // protection bits carry no meaning here
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:4], s_axi_wstrb[3:1]};

endmodule // gpiod_top
`default_nettype wire

// ==== verif/gpiod_board.sv ====
// board model: the level each pin settles to from device drive and board
`timescale 1ns/1ps
`default_nettype none
module gpiod_board
  import gpiod_pkg::*;
(
  input  wire gpiod_drive_s pin_drive,
  input  wire gpiod_port_t  board_level,
  output var  gpiod_port_t  pin_in
);
  // driven pins follow the latch, floating ones take whatever the board sets
  assign pin_in = (pin_drive.out & ~pin_drive.oe_n) | (board_level & pin_drive.oe_n);
endmodule // gpiod_board
`default_nettype wire

// ==== verif/gpiod_chk.sv ====
// concurrent checks on the port block's bus and pin ports
`timescale 1ns/1ps
`default_nettype none
module gpiod_chk
  import gpiod_pkg::*;
#(parameter int unsigned ADDR_W = 12) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire gpiod_drive_s      pin_drive
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken on one edge, the only way the bench offers them
  wire logic aw_w = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  chk_hole_undriven: assert property (&(pin_drive.oe_n | GPIOD_PIN_MASK))
    else $error("absent pin driven");
  chk_out_gated: assert property ((pin_drive.out & pin_drive.oe_n) == '0)
    else $error("undriven pin shows data");
  chk_write_resp: assert property (aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer off time");
  chk_ready_drop: assert property (aw_w |=> !s_axi_awready && !s_axi_wready)
    else $error("write readies stay up");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while pending");
  // enables land one edge after the register, so three samples on
  chk_dir_pins: assert property (aw_w && s_axi_awaddr[9:2] == GPIOD_IDX_DIR_0A
    && s_axi_wstrb[0] |-> ##3 pin_drive.oe_n[0] == ~$past(s_axi_wdata[3:0], 3))
    else $error("port 0a enables wrong");
  for (genvar g = 8; g < 12; g++) begin : grp
    chk_group_whole: assert property (pin_drive.oe_n[g] inside {4'h0, 4'hf})
      else $error("group port split");
  end
endmodule // gpiod_chk
////////////////////////////////////////////////////////////////
bind gpiod_top gpiod_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ==== verif/gpiod_tb_top.sv ====
// self-checking bench for the port direction block
`timescale 1ns/1ps
`default_nettype none
module gpiod_tb_top
  import gpiod_pkg::*;
;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, stop;
  logic              s_axi_arvalid, s_axi_rready;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata;
  logic [3:0]        s_axi_wstrb;
  wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic         clock_stop;
  wire logic [1:0]   s_axi_bresp, s_axi_rresp;
  wire logic [31:0]  s_axi_rdata;
  wire gpiod_drive_s drv;
  wire gpiod_port_t  pin_in;
  gpiod_port_t       board, lat, dirs;
  int                failures = 0, check_count = 0, cyc = 0;
  gpiod_top u_dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .pin_drive(drv), .*);
  gpiod_board u_board (.pin_drive(drv), .board_level(board), .pin_in(pin_in));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // runaway guard, far beyond the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////
  // handshakes judged at the falling edge, where nothing moves
  task automatic wr(input logic [7:0] i, input gpiod_nib_t d, input logic s, input logic [1:0] er);
    logic a, w, b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {28'h0, d};
    s_axi_wstrb <= {3'h0, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      if (b) chk("bresp", {46'h0, er}, {46'h0, s_axi_bresp});
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [47:0] e, input logic [1:0] er);
    logic a, v;
    v = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!v) begin
      @(negedge aclk);
      a = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid & s_axi_rready;
      if (v) chk("rdata", e, {16'h0, s_axi_rdata});
      if (v) chk("rresp", {46'h0, er}, {46'h0, s_axi_rresp});
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (v) s_axi_rready <= 1'b0;
    end
  endtask
  // outputs read back the latch, inputs the board level unless stopped
  function automatic logic [47:0] exp_rd(input int k);
    gpiod_nib_t lvl;
    lvl = stop ? 4'h0 : board[k];
    return {44'h0, GPIOD_PIN_MASK[k] & ((dirs[k] & lat[k]) | (~dirs[k] & lvl))};
  endfunction
  initial begin
    int k;
    gpiod_nib_t d;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, stop} = '0;
    {board, lat, dirs} = '0;
    void'($urandom(32'h63069055));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    step(1);
    chk("oe_n", '1, drv.oe_n);
    rd(GPIOD_IDX_DIR_0A, 48'h0, GPIOD_RESP_OKAY);
    wr(GPIOD_IDX_DIR_0A, 4'hf, 1'b1, GPIOD_RESP_OKAY);
    wr(GPIOD_IDX_DIR_0A, 4'h0, 1'b0, GPIOD_RESP_OKAY);
    rd(GPIOD_IDX_DIR_0A, 48'hf, GPIOD_RESP_OKAY);
    dirs[0] = 4'hf;
    wr(8'h00, 4'h5, 1'b1, GPIOD_RESP_SLVERR);
    rd(8'h00, 48'h0, GPIOD_RESP_SLVERR);
    for (int n = 0; n < 24; n++) begin
      k = n % 12;
      d = 4'($urandom);
      board <= 48'({$urandom, $urandom});
      if (k < 8) begin
        wr(GPIOD_IDX_DIR_0A - 8'(k), d, 1'b1, GPIOD_RESP_OKAY);
        dirs[k] = d;
        rd(GPIOD_IDX_DIR_0A - 8'(k), {44'h0, d}, GPIOD_RESP_OKAY);
      end else begin
        wr(GPIOD_IDX_GROUP, d, 1'b1, GPIOD_RESP_OKAY);
        for (int j = 0; j < 4; j++) dirs[8+j] = {4{d[j]}};
        rd(GPIOD_IDX_GROUP, {44'h0, d}, GPIOD_RESP_OKAY);
      end
      d = 4'($urandom);
      wr(GPIOD_IDX_DATA_LO + 8'(k), d, 1'b1, GPIOD_RESP_OKAY);
      lat[k] = d;
      step(1);
      chk("oe_n", ~(dirs & GPIOD_PIN_MASK), drv.oe_n);
      chk("out", lat & dirs & GPIOD_PIN_MASK, drv.out);
      rd(GPIOD_IDX_DATA_LO + 8'(k), exp_rd(k), GPIOD_RESP_OKAY);
    end
    wr(GPIOD_IDX_STOP, 4'h1, 1'b1, GPIOD_RESP_OKAY);
    stop = 1'b1;
    step(1);
    chk("clock_stop", 48'h1, {47'h0, clock_stop});
    rd(GPIOD_IDX_STOP, 48'h1, GPIOD_RESP_OKAY);
    rd(GPIOD_IDX_DATA_LO + 8'h1, exp_rd(1), GPIOD_RESP_OKAY);
    wr(GPIOD_IDX_STOP, 4'h0, 1'b1, GPIOD_RESP_OKAY);
    stop = 1'b0;
    step(3);
    rd(GPIOD_IDX_DATA_LO + 8'h1, exp_rd(1), GPIOD_RESP_OKAY);
    // mid-run reset: modes fall back to input, latches and stop clear
    wr(GPIOD_IDX_STOP, 4'h1, 1'b1, GPIOD_RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    {dirs, lat, stop} = '0;
    step(1);
    chk("oe_n", '1, drv.oe_n);
    chk("clock_stop", 48'h0, {47'h0, clock_stop});
    rd(GPIOD_IDX_DIR_0A, 48'h0, GPIOD_RESP_OKAY);
    rd(GPIOD_IDX_DATA_LO + 8'h2, exp_rd(2), GPIOD_RESP_OKAY);
    results();
  end
endmodule // gpiod_tb_top
`default_nettype wire
